/* hw/aux_master_regs.sv */
// Register bank for auxiliary slave write bytes, reduced-rate access,
// sensor path clearing and accelerometer wake delay, on AHB-Lite.
// Assumes the bus engine, sensor paths and master delay count live
// outside and share sys_clk.
//
// Notes on behaviour
// - Slaves 1 to 3 each own a read/write byte sent on write transfers.
// - Hold bit set: shadow copy waits until the whole sample arrived.
// - Bits 4..0 pick reduced-rate access for slaves 4 down to 0.
// - Reduced slave accessed once per one plus skip count samples.
// - Sample tick comes from divider setting and lowpass setting.
// - Bits 6 and 5 of the rate register are reserved.
// - Path clear write: bit 2 gyro, bit 1 accel, bit 0 temperature.
// - A path clear returns converters and filters to power-up state.
// - A path clear leaves measurement registers untouched.
// - Bits 7 to 3 of the path clear register are ignored.
// - Wake delay is 4 ms plus field bits 5:4 in whole ms.
// - Motion detection held idle until the wake delay has elapsed.
// - Bits 7, 6 and 3..0 of the wake delay register are reserved.
// - Slaves are visited in ascending order each sample.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module aux_master_regs
#(
  parameter int FAST_PERIOD = aux_regs_pkg::FAST_CYCLES, // 8 kHz rate
  parameter int SLOW_PERIOD = aux_regs_pkg::SLOW_CYCLES, // 1 kHz rate
  parameter int MS_PERIOD = aux_regs_pkg::MS_CYCLES // One millisecond
)
(
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic [7:0] sample_divider, // Sample rate divider
  input wire logic [2:0] lowpass_setting, // Lowpass configuration
  input wire logic [4:0] master_skip_count, // Master delay count
  input wire logic [4:0] slave_enable, // Slaves enabled for access
  input wire logic accel_wake, // Accelerometer wake-up pulse
  input wire logic ext_byte_received, // One sensor byte received
  input wire logic ext_sample_complete, // All bytes of sample received
  output logic [7:0] aux_slave1_write_byte, // Slave 1 write byte
  output logic [7:0] aux_slave2_write_byte, // Slave 2 write byte
  output logic [7:0] aux_slave3_write_byte, // Slave 3 write byte
  output logic [4:0] slave_access_go, // One-hot access pulse
  output logic ext_shadow_copy, // Copy sensor data pulse
  output logic rate_sensor_path_clear, // Gyro path clear pulse
  output logic linear_motion_path_clear, // Accel path clear pulse
  output logic temp_path_clear, // Temperature path clear pulse
  output logic motion_detect_hold // Motion detection held idle
);

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  function automatic logic hit(input logic [9:0] idx,
                               input logic [9:0] want);
    hit = (idx == want);
  endfunction : hit

  logic addr_ok;
  logic [9:0] addr_idx;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [9:0] idx_reg;
  logic [7:0] wbyte;
  logic do_write;

  assign addr_ok = hsel && htrans[1] && hready;
  assign addr_idx = haddr[11:2];
  assign wbyte = hwdata[7:0];
  assign do_write = wr_pend_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 10'h000;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      if (addr_ok)
      begin
        idx_reg <= addr_idx;
      end
    end
  end

  // Reads wait one cycle because hrdata is registered from rd_byte
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(addr_ok && !hwrite);
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic wr_slv1;
  logic wr_slv2;
  logic wr_slv3;
  logic wr_rate;
  logic wr_clear;
  logic wr_wake;

  assign wr_slv1 = do_write && hit(idx_reg, aux_regs_pkg::IDX_SLAVE1_BYTE);
  assign wr_slv2 = do_write && hit(idx_reg, aux_regs_pkg::IDX_SLAVE2_BYTE);
  assign wr_slv3 = do_write && hit(idx_reg, aux_regs_pkg::IDX_SLAVE3_BYTE);
  assign wr_rate = do_write
                   && hit(idx_reg, aux_regs_pkg::IDX_RATE_REDUCTION);
  assign wr_clear = do_write && hit(idx_reg, aux_regs_pkg::IDX_PATH_CLEAR);
  assign wr_wake = do_write && hit(idx_reg, aux_regs_pkg::IDX_WAKE_DELAY);

  // ****************************************************************
  // Stored registers
  // ****************************************************************
  logic [7:0] rate_reg;
  logic [7:0] wake_reg;
  logic hold_copy_until_complete;
  logic [4:0] slow_access;
  logic [1:0] wake_extra_delay;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aux_slave1_write_byte <= aux_regs_pkg::BYTE_RESET;
      aux_slave2_write_byte <= aux_regs_pkg::BYTE_RESET;
      aux_slave3_write_byte <= aux_regs_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr_slv1)
      begin
        aux_slave1_write_byte <= wbyte;
      end
      if (wr_slv2)
      begin
        aux_slave2_write_byte <= wbyte;
      end
      if (wr_slv3)
      begin
        aux_slave3_write_byte <= wbyte;
      end
    end
  end

  // Reserved bits are dropped so they read back as zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rate_reg <= aux_regs_pkg::BYTE_RESET;
      wake_reg <= aux_regs_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr_rate)
      begin
        rate_reg <= wbyte & aux_regs_pkg::RATE_MASK;
      end
      if (wr_wake)
      begin
        wake_reg <= wbyte & aux_regs_pkg::WAKE_MASK;
      end
    end
  end

  assign hold_copy_until_complete = rate_reg[aux_regs_pkg::HOLD_COPY_BIT];
  assign slow_access = rate_reg[aux_regs_pkg::SLOW_ACCESS_MSB:0];
  assign wake_extra_delay =
    wake_reg[aux_regs_pkg::WAKE_EXTRA_MSB:aux_regs_pkg::WAKE_EXTRA_LSB];

  // ****************************************************************
  // Sensor path clear strobes
  // ****************************************************************
  // Only the path logic is cleared; measurement registers are kept
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rate_sensor_path_clear <= 1'b0;
      linear_motion_path_clear <= 1'b0;
      temp_path_clear <= 1'b0;
    end
    else
    begin
      rate_sensor_path_clear <= wr_clear
        && wbyte[aux_regs_pkg::RATE_PATH_BIT];
      linear_motion_path_clear <= wr_clear
        && wbyte[aux_regs_pkg::LINEAR_PATH_BIT];
      temp_path_clear <= wr_clear
        && wbyte[aux_regs_pkg::TEMP_PATH_BIT];
    end
  end

  // ****************************************************************
  // Sample tick
  // ****************************************************************
  logic lowpass_off;
  logic [17:0] rate_period;
  logic rate_tick;
  logic [7:0] div_cnt_reg;
  logic sample_tick_reg;

  assign lowpass_off = (lowpass_setting == aux_regs_pkg::LOWPASS_OFF_A)
                       || (lowpass_setting == aux_regs_pkg::LOWPASS_OFF_B);
  assign rate_period = lowpass_off ? 18'(FAST_PERIOD)
                                   : 18'(SLOW_PERIOD);

  pulse_divider rate_div
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(1'b0),
    .period(rate_period),
    .tick(rate_tick)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_reg <= 8'h00;
      sample_tick_reg <= 1'b0;
    end
    else
    begin
      sample_tick_reg <= rate_tick && (div_cnt_reg >= sample_divider);
      if (rate_tick)
      begin
        div_cnt_reg <= (div_cnt_reg >= sample_divider) ? 8'h00
                       : div_cnt_reg + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Reduced-rate skip counters
  // ****************************************************************
  logic [4:0] due_reg;

  genvar s;
  generate
    for (s = 0; s < aux_regs_pkg::NUM_SLAVES; s++)
    begin : g_skip
      logic [4:0] skip_reg;
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          skip_reg <= 5'h00;
          due_reg[s] <= 1'b0;
        end
        else if (sample_tick_reg)
        begin
          due_reg[s] <= !slow_access[s] || (skip_reg == 5'h00);
          skip_reg <= (skip_reg >= master_skip_count) ? 5'h00
                      : skip_reg + 5'h01;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Slave access sequence
  // ****************************************************************
  aux_regs_pkg::seq_state_t state_reg;
  aux_regs_pkg::seq_state_t state_next;
  logic [2:0] slot_reg;
  logic [4:0] slot_hot;
  logic [4:0] go_next;

  assign slot_hot = 5'h01 << slot_reg;
  assign go_next = (state_reg == aux_regs_pkg::SEQ_STEP)
                   ? (slot_hot & slave_enable & due_reg) : 5'h00;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      aux_regs_pkg::SEQ_IDLE:
      begin
        if (sample_tick_reg)
        begin
          state_next = aux_regs_pkg::SEQ_STEP;
        end
      end
      aux_regs_pkg::SEQ_STEP:
      begin
        if (slot_reg == aux_regs_pkg::LAST_SLOT)
        begin
          state_next = aux_regs_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  // Due flags settle one cycle after the tick, as the sequence starts
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= aux_regs_pkg::SEQ_IDLE;
      slot_reg <= 3'h0;
      slave_access_go <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      slave_access_go <= go_next;
      slot_reg <= (state_reg == aux_regs_pkg::SEQ_STEP)
                  ? slot_reg + 3'h1 : 3'h0;
    end
  end

  // ****************************************************************
  // External data shadow copy
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_shadow_copy <= 1'b0;
    end
    else
    begin
      ext_shadow_copy <= hold_copy_until_complete ? ext_sample_complete
                         : ext_byte_received;
    end
  end

  // ****************************************************************
  // Accelerometer wake delay
  // ****************************************************************
  logic ms_tick;

  pulse_divider ms_div
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(accel_wake),
    .period(18'(MS_PERIOD)),
    .tick(ms_tick)
  );

  // A zero extra field still gives the 4 ms floor
  wake_timer wake
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(accel_wake),
    .ms_tick(ms_tick),
    .extra_ms(wake_extra_delay),
    .busy(motion_detect_hold)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  assign status_byte = {5'h00, state_reg == aux_regs_pkg::SEQ_STEP,
                        hold_copy_until_complete, motion_detect_hold};
  assign rd_byte =
    hit(idx_reg, aux_regs_pkg::IDX_SLAVE1_BYTE) ? aux_slave1_write_byte :
    hit(idx_reg, aux_regs_pkg::IDX_SLAVE2_BYTE) ? aux_slave2_write_byte :
    hit(idx_reg, aux_regs_pkg::IDX_SLAVE3_BYTE) ? aux_slave3_write_byte :
    hit(idx_reg, aux_regs_pkg::IDX_RATE_REDUCTION) ? rate_reg :
    hit(idx_reg, aux_regs_pkg::IDX_WAKE_DELAY) ? wake_reg :
    hit(idx_reg, aux_regs_pkg::IDX_STATUS) ? status_byte :
    8'h00;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend_reg)
    begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule : aux_master_regs

/* hw/aux_regs_pkg.sv */
// Constants shared by the auxiliary master control register bank.
// Assumes a 200 MHz system clock and a word-wide AHB-Lite register bus.
package aux_regs_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [9:0] IDX_SLAVE1_BYTE = 10'h064;
  localparam logic [9:0] IDX_SLAVE2_BYTE = 10'h065;
  localparam logic [9:0] IDX_SLAVE3_BYTE = 10'h066;
  localparam logic [9:0] IDX_RATE_REDUCTION = 10'h067;
  localparam logic [9:0] IDX_PATH_CLEAR = 10'h068;
  localparam logic [9:0] IDX_WAKE_DELAY = 10'h069;
  localparam logic [9:0] IDX_STATUS = 10'h070;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int HOLD_COPY_BIT = 7;
  localparam int SLOW_ACCESS_MSB = 4;
  localparam int WAKE_EXTRA_LSB = 4;
  localparam int WAKE_EXTRA_MSB = 5;
  localparam int RATE_PATH_BIT = 2;
  localparam int LINEAR_PATH_BIT = 1;
  localparam int TEMP_PATH_BIT = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] RATE_MASK = 8'h9F;
  localparam logic [7:0] WAKE_MASK = 8'h30;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 200000000;
  localparam int FAST_RATE_HZ = 8000;
  localparam int SLOW_RATE_HZ = 1000;
  localparam int MS_PER_S = 1000;
  localparam int FAST_CYCLES = CLK_HZ / FAST_RATE_HZ;
  localparam int SLOW_CYCLES = CLK_HZ / SLOW_RATE_HZ;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [2:0] WAKE_BASE_MS = 3'h4;
  localparam logic [2:0] LOWPASS_OFF_A = 3'h0;
  localparam logic [2:0] LOWPASS_OFF_B = 3'h7;
  localparam int NUM_SLAVES = 5;
  localparam logic [2:0] LAST_SLOT = 3'h4;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_STEP = 2'b10
  } seq_state_t;

endpackage : aux_regs_pkg

/* hw/pulse_divider.sv */
// Free counter that emits one-cycle ticks at a programmable period.
// Assumes period is at least one; restart realigns the phase.
`timescale 1ns/10ps
module pulse_divider
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic restart, // Restart the period
  input wire logic [17:0] period, // Cycles per tick
  output logic tick // One-cycle tick
);
  logic [17:0] count_reg;
  logic wrap;

  assign wrap = (count_reg >= period - 18'h0_0001);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= 18'h0_0000;
      tick <= 1'b0;
    end
    else
    begin
      count_reg <= (restart || wrap) ? 18'h0_0000 : count_reg + 18'h0_0001;
      tick <= wrap && !restart;
    end
  end
endmodule : pulse_divider

/* hw/wake_timer.sv */
// Counts the accelerometer wake-up delay in whole milliseconds.
// Assumes ms_tick is restarted together with start.
`timescale 1ns/10ps
module wake_timer
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic start, // Wake-up event pulse
  input wire logic ms_tick, // One pulse per millisecond
  input wire logic [1:0] extra_ms, // Added delay in ms
  output logic busy // Delay still running
);
  logic [2:0] left_reg;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      left_reg <= 3'h0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      left_reg <= aux_regs_pkg::WAKE_BASE_MS + {1'b0, extra_ms};
      busy <= 1'b1;
    end
    else if (busy && ms_tick)
    begin
      left_reg <= left_reg - 3'h1;
      busy <= (left_reg != 3'h1);
    end
  end
endmodule : wake_timer

/* test/aux_master_regs_asserts.sv */
// Concurrent checks on the ports of the auxiliary master register bank.
// Assumes hready is fed back from hreadyout and MS_PERIOD is small.
`timescale 1ns/10ps
module aux_master_regs_asserts
#(
  parameter int MS_PERIOD = 10 // Cycles per millisecond
)
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [4:0] slave_enable, // Slave enables
  input wire logic accel_wake, // Wake pulse
  input wire logic ext_byte_received, // Byte pulse
  input wire logic ext_sample_complete, // Sample pulse
  input wire logic [4:0] slave_access_go, // Access pulses
  input wire logic ext_shadow_copy, // Copy pulse
  input wire logic rate_sensor_path_clear, // Gyro clear
  input wire logic linear_motion_path_clear, // Accel clear
  input wire logic temp_path_clear // Temperature clear
  ,input wire logic motion_detect_hold // Detection hold
);
  // Fall window after 8 held cycles: 4 to 7 ms with a little slack
  localparam int WAKE_LO = 4 * MS_PERIOD - 9;
  localparam int WAKE_HI = 7 * MS_PERIOD - 6;
  wire take = hsel & htrans[1] & hready;
  wire wr_clear = take & hwrite & (haddr == 32'h0000_01A0);
  wire [2:0] clear_bits = hwdata[2:0];
  wire [2:0] clears = {rate_sensor_path_clear, linear_motion_path_clear,
    temp_path_clear};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence wake_span;
    motion_detect_hold [*8] ##[WAKE_LO:WAKE_HI] $fell(motion_detect_hold);
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  read_wait_a: assert property (take && !hwrite |=> read_wait)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  go_enabled_a: assert property (
    (slave_access_go & ~slave_enable) == 0)
    else $error("access to disabled slave");
  go_order_a: assert property (slave_access_go != 0 |=>
    slave_access_go == 0 || slave_access_go > $past(slave_access_go))
    else $error("slave order not ascending");
  go_onehot_a: assert property ($onehot0(slave_access_go))
    else $error("two slaves at once");
  shadow_cause_a: assert property (ext_shadow_copy |->
    $past(ext_byte_received) || $past(ext_sample_complete))
    else $error("copy without cause");
  clear_match_a: assert property ($past(wr_clear, 2) |->
    clears == $past(clear_bits)) else $error("path clear mismatch");
  clear_cause_a: assert property (
    clears != 0 |-> $past(wr_clear, 2))
    else $error("path clear without write");
  wake_hold_a: assert property (accel_wake |=> wake_span)
    else $error("wake hold span wrong");
endmodule : aux_master_regs_asserts
bind aux_master_regs aux_master_regs_asserts #(.MS_PERIOD(MS_PERIOD)) chk (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .slave_enable(slave_enable), .accel_wake(accel_wake),
  .ext_byte_received(ext_byte_received),
  .ext_sample_complete(ext_sample_complete),
  .slave_access_go(slave_access_go), .ext_shadow_copy(ext_shadow_copy),
  .rate_sensor_path_clear(rate_sensor_path_clear),
  .linear_motion_path_clear(linear_motion_path_clear),
  .temp_path_clear(temp_path_clear), .motion_detect_hold(motion_detect_hold));

/* test/ahb_host_model.sv */
// Host processor model: single word AHB-Lite transfers on request.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module ahb_host_model
(
  input wire logic sys_clk, // Clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Select
  output logic [31:0] haddr, // Address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write
  output logic [2:0] hsize, // Size, word
  output logic [31:0] hwdata // Write data
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Unused write data is inverted so stale values never look valid
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : ahb_host_model

/* test/test_aux_master_regs.sv */
// Self-checking bench for the auxiliary master register bank.
// Assumes shortened rate periods of 20, 40 and 10 cycles.
`timescale 1ns/10ps
module test_aux_master_regs;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, wake, byte_in, done;
  logic copy, hold, clr_r, clr_l, clr_t;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, lowpass, last_clr;
  logic [7:0] divider, b1, b2, b3;
  logic [4:0] skip, enable, go;
  int errors, tests_run, copies, clrs, gap, base;
  int cnt [5];
  bit counting;
  ahb_host_model host (.sys_clk(sys_clk), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  aux_master_regs #(.FAST_PERIOD(20), .SLOW_PERIOD(40), .MS_PERIOD(10)) uut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sample_divider(divider), .lowpass_setting(lowpass),
    .master_skip_count(skip), .slave_enable(enable), .accel_wake(wake),
    .ext_byte_received(byte_in), .ext_sample_complete(done),
    .aux_slave1_write_byte(b1), .aux_slave2_write_byte(b2),
    .aux_slave3_write_byte(b3), .slave_access_go(go),
    .ext_shadow_copy(copy), .rate_sensor_path_clear(clr_r),
    .linear_motion_path_clear(clr_l), .temp_path_clear(clr_t),
    .motion_detect_hold(hold));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (copy === 1'b1) copies++;
    if ({clr_r, clr_l, clr_t} !== 3'b000)
    begin
      clrs++;
      last_clr = {clr_r, clr_l, clr_t};
    end
    for (int i = 0; i < 5; i++)
      if (counting && go[i] === 1'b1) cnt[i]++;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [31:0] adr(input logic [9:0] i);
    return {20'h0_0000, i, 2'b00};
  endfunction : adr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("BAD at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    host.xfer(adr(i), 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [31:0] exp);
    host.xfer(adr(i), 1'b0, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd
  task automatic wait_go0(output int n);
    n = 1;
    @(posedge sys_clk);
    while (go[0] !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_go0
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    {wake, byte_in, done, counting} = '0;
    {divider, lowpass, skip, enable} = {8'h00, 3'h0, 5'h02, 5'h17};
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(10'(aux_regs_pkg::IDX_SLAVE1_BYTE + i), 0);
    wr(aux_regs_pkg::IDX_SLAVE1_BYTE, 32'h0000_00A5);
    wr(aux_regs_pkg::IDX_SLAVE2_BYTE, 32'h0000_005A);
    wr(aux_regs_pkg::IDX_SLAVE3_BYTE, 32'h0000_00C3);
    // The last byte lands on the edge the write task returns at
    @(posedge sys_clk);
    chk({8'h00, b1, b2, b3}, 32'h00A5_5AC3);
    rd(aux_regs_pkg::IDX_SLAVE2_BYTE, 32'h0000_005A);
    wr(10'h07F, 32'h0000_00FF);
    rd(10'h07F, 32'h0000_0000);
    wr(aux_regs_pkg::IDX_RATE_REDUCTION, 32'h0000_00FF);
    rd(aux_regs_pkg::IDX_RATE_REDUCTION, 32'h0000_009F);
    wr(aux_regs_pkg::IDX_WAKE_DELAY, 32'h0000_00FF);
    rd(aux_regs_pkg::IDX_WAKE_DELAY, 32'h0000_0030);
    for (int i = 0; i < 3; i++)
    begin
      wr(aux_regs_pkg::IDX_PATH_CLEAR,
        32'h0000_00F8 | 32'(1 << i));
      repeat (2) @(posedge sys_clk);
      chk({29'h0, last_clr}, 32'(1 << i));
      rd(aux_regs_pkg::IDX_PATH_CLEAR, 32'h0000_0000);
    end
    chk_rng(clrs, 3, 3);
    for (int h = 0; h < 2; h++)
    begin
      wr(aux_regs_pkg::IDX_RATE_REDUCTION,
        h ? 32'h0000_0080 : 32'h0000_0000);
      base = copies;
      @(posedge sys_clk) byte_in <= 1'b1;
      @(posedge sys_clk) byte_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_rng(copies - base, 1 - h, 1 - h);
      @(posedge sys_clk) done <= 1'b1;
      @(posedge sys_clk) done <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_rng(copies - base, 1, 1);
    end
    // Sequence running bit depends on tick phase, so it is masked
    host.xfer(adr(aux_regs_pkg::IDX_STATUS), 1'b0, 32'h0000_0000, q);
    chk(q & 32'hFFFF_FFFB, 32'h0000_0002);
    wr(aux_regs_pkg::IDX_RATE_REDUCTION, 32'h0000_0002);
    wait_go0(gap);
    repeat (8) @(posedge sys_clk);
    counting <= 1'b1;
    for (int n = 0; n < 2000 && cnt[0] < 30; n++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    counting <= 1'b0;
    chk_rng(cnt[1], 10, 10);
    chk_rng(cnt[2] + cnt[4], 60, 60);
    chk_rng(cnt[3], 0, 0);
    for (int k = 0; k < 4; k++)
    begin
      divider <= 8'(k / 2 + k / 3);
      // Settings 0, 4, 6 and 7 reach both unfiltered codes
      lowpass <= (k == 3) ? 3'h7 : 3'(k * 3 + (k == 1));
      wait_go0(gap);
      wait_go0(gap);
      wait_go0(gap);
      chk_rng(gap, (k % 3 == 0 ? 20 : 40) * (1 + k / 2 + k / 3),
        (k % 3 == 0 ? 20 : 40) * (1 + k / 2 + k / 3));
    end
    for (int e = 1; e < 4; e++)
    begin
      wr(aux_regs_pkg::IDX_WAKE_DELAY, 32'(e << 4));
      @(posedge sys_clk) wake <= 1'b1;
      @(posedge sys_clk) wake <= 1'b0;
      @(posedge sys_clk);
      gap = 0;
      while (hold === 1'b1 && gap < 200)
      begin
        @(posedge sys_clk);
        gap++;
      end
      chk_rng(gap, (4 + e) * 10 - 1, (4 + e) * 10 + 3);
    end
    wrap_up();
  end
endmodule : test_aux_master_regs
